// file: wdt_pkg.sv
// Package: register map, field layout and constants of the watchdog block
package wdt_pkg;

	// Register byte offsets (printed offsets are not all multiples of four: index * 4)
	localparam logic [7:0]  IDX_POWER_MODE_CONTROL = 8'h87;
	localparam logic [7:0]  IDX_WATCHDOG_CONTROL   = 8'h8F;
	localparam logic [7:0]  IDX_IRQ_STATUS         = 8'h90;
	localparam logic [7:0]  IDX_IRQ_MASK           = 8'h91;
	localparam logic [7:0]  IDX_WDT_COUNT          = 8'h92;
	localparam logic [11:0] ADDR_POWER_MODE_CONTROL = {2'h0, IDX_POWER_MODE_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_WATCHDOG_CONTROL   = {2'h0, IDX_WATCHDOG_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_IRQ_STATUS         = {2'h0, IDX_IRQ_STATUS, 2'h0};
	localparam logic [11:0] ADDR_IRQ_MASK           = {2'h0, IDX_IRQ_MASK, 2'h0};
	localparam logic [11:0] ADDR_WDT_COUNT          = {2'h0, IDX_WDT_COUNT, 2'h0};

	// Watchdog control field positions
	localparam int WDC_ENABLE   = 7;
	localparam int WDC_CLEAR    = 6;
	localparam int WDC_IDLE_RUN = 3;
	localparam int WDC_PS_MSB   = 2;
	localparam int WDC_PS_LSB   = 0;

	// Power mode control field positions
	localparam int PMC_POWER_OFF = 4;
	localparam int PMC_USER_ONE  = 3;
	localparam int PMC_USER_ZERO = 2;
	localparam int PMC_PDOWN     = 1;
	localparam int PMC_IDLE      = 0;

	// Interrupt status bits
	localparam int IRQ_TIMEOUT = 0;
	localparam int IRQ_WAKE    = 1;

	// Reset values
	localparam logic [7:0] WDC_RESET = 8'h00;
	localparam logic [7:0] PMC_RESET = 8'h00;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// Timing
	localparam int          CLK_MHZ          = 100;
	localparam int          OSC_PER_MACHINE  = 12;
	localparam logic [3:0]  MACHINE_LAST     = 4'(OSC_PER_MACHINE - 1);
	localparam int          WDT_BITS         = 14;
	localparam int          PRE_BITS         = 8;
	localparam int          RESET_MIN_CYCLES = 2;
	localparam logic [4:0]  RESET_FILT_LAST  = 5'(RESET_MIN_CYCLES * OSC_PER_MACHINE - 1);
	localparam logic [3:0]  SAMPLE_PHASE     = 4'h9; // Fifth state, second phase

	// AXI4-Lite responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Power mode states
	typedef enum logic [2:0] {
		PM_RUN   = 3'b001,
		PM_IDLE  = 3'b010,
		PM_PDOWN = 3'b100
	} pmode_t;

	// Read channel payload
	typedef struct packed {
		logic [31:0] data;
		logic [1:0]  resp;
	} rd_beat_t;

endpackage

// file: wdt_top.sv
// Watchdog, power mode and reset control with AXI4-Lite register slave
`timescale 1ns/1ps

// Behaviour
// [R1] Divided clock chain; timeout resets when enabled
// [R2] Watchdog disabled after any reset
// [R3] Counter runs only while enable set
// [R4] Clear bit zeroes counter, prescaler, itself
// [R5] Software clears before timeout elapses
// [R6] Idle-run bit gates counting in idle
// [R7] Prescaler select decodes 2 to 256
// [R8] Timeout after 2^14 x prescale x 12
// [R9] Any reset clears counter and prescaler
// [R10] Oscillator divided by two internally
// [R11] Idle stops cpu clock; interrupt wakes
// [R12] Power-down stops all; only reset exits
// [R13] Reset sampled at state five phase two
// [R14] Reset input filtered against glitches
// [R15] Reset clears registers; power flag kept; interrupt status and mask are cleared only by i_rstn
// [R16] Power-off flag set on power-on only; a software write of one to the flag also sets it
// [R17] Two free user flag bits
// [R18] Prescaler steps once per machine cycle
// [R19] Idle halt holds counter and prescaler
module wdt_top
	import wdt_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// External reset pin, active high, and power-on indication
	input  wire logic        i_ext_reset,
	input  wire logic        i_power_on,
	// Interrupt from the core's peripherals, wakes idle
	input  wire logic        i_wake_irq,
	// AXI4-Lite write address
	input  wire logic [11:0] i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	// AXI4-Lite write response
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	// AXI4-Lite read address
	input  wire logic [11:0] i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	// AXI4-Lite read data
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	// Clocks and system outputs
	output logic             o_half_clk,
	output logic             o_cpu_clk_en,
	output logic             o_osc_en,
	output logic             o_sys_reset,
	output logic             o_irq
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0]          wdc_r;
	logic [4:0]          pmc_r;
	logic [1:0]          irq_stat_r;
	logic [1:0]          irq_mask_r;
	pmode_t              pmode_r;
	logic [3:0]          phase_r;
	logic [PRE_BITS-1:0] pre_r;
	logic [WDT_BITS-1:0] cnt_r;
	logic [4:0]          filt_r;
	logic                rst_sample_r;
	logic                wd_reset_r;
	logic                int_rst;
	logic                machine_tick;
	logic                wd_run;
	logic                pre_tick;
	logic [PRE_BITS-1:0] pre_last;
	logic                timeout;
	logic                aw_full_r;
	logic                w_full_r;
	logic [11:0]         aw_addr_r;
	logic [31:0]         w_data_r;
	logic                w_lane0_r;
	logic                wr_go;
	logic                wr_hit;
	rd_beat_t            rd_beat;

	////////////////////////////////////////////////////////////////////////////
	// Clocking

	// [R10] Divide by two
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_half_clk <= 1'b0;
		end else if (pmode_r == PM_PDOWN) begin
			o_half_clk <= 1'b0;
		end else begin
			o_half_clk <= ~o_half_clk;
		end
	end

	// Machine cycle phase, twelve oscillator periods
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			phase_r <= 4'h0;
		end else if (pmode_r == PM_PDOWN) begin
			phase_r <= phase_r; // Oscillator halted
		end else if (phase_r == MACHINE_LAST) begin
			phase_r <= 4'h0;
		end else begin
			phase_r <= phase_r + 4'h1;
		end
	end

	assign machine_tick = (phase_r == MACHINE_LAST) && (pmode_r != PM_PDOWN);

	////////////////////////////////////////////////////////////////////////////
	// Reset filter and sampling

	// [R14] Pin must stay high for two machine cycles
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			filt_r <= 5'h00;
		end else if (!i_ext_reset) begin
			filt_r <= 5'h00;
		end else if (filt_r != RESET_FILT_LAST) begin
			filt_r <= filt_r + 5'h01;
		end
	end

	// [R13] Filtered level sampled at state five phase two
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			rst_sample_r <= 1'b0;
		end else if (!i_ext_reset) begin
			rst_sample_r <= 1'b0; // Stray glitches never latch
		end else if (phase_r == SAMPLE_PHASE || pmode_r == PM_PDOWN) begin
			// Phase is frozen in power-down, so sample on every clock there
			rst_sample_r <= (filt_r == RESET_FILT_LAST);
		end
	end

	assign int_rst = rst_sample_r | wd_reset_r | i_power_on;

	// System reset output
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_sys_reset <= 1'b1;
		end else begin
			o_sys_reset <= int_rst;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Watchdog

	// [R3] Run gate; [R6] idle-run gate
	assign wd_run = wdc_r[WDC_ENABLE] &&
		((pmode_r == PM_RUN) || ((pmode_r == PM_IDLE) && wdc_r[WDC_IDLE_RUN]));

	// [R7] Prescaler select decode, field order is irregular
	always_comb begin
		case (wdc_r[WDC_PS_MSB:WDC_PS_LSB])
			3'b000:  pre_last = 8'h01;
			3'b010:  pre_last = 8'h03;
			3'b001:  pre_last = 8'h07;
			3'b011:  pre_last = 8'h0F;
			3'b100:  pre_last = 8'h1F;
			3'b101:  pre_last = 8'h3F;
			3'b110:  pre_last = 8'h7F;
			default: pre_last = 8'hFF;
		endcase
	end

	assign pre_tick = machine_tick && wd_run && (pre_r == pre_last);
	// [R8] Full 14-bit wrap ends the interval
	assign timeout  = pre_tick && (cnt_r == {WDT_BITS{1'b1}});

	// [R18] Prescaler per machine cycle; [R19] held when halted
	always_ff @(posedge i_clk) begin
		if (!i_rstn || int_rst) begin
			// [R9] Cleared on reset
			pre_r <= '0;
		end else if (wdc_r[WDC_CLEAR] && machine_tick) begin
			// [R4] Clear on next machine cycle
			pre_r <= '0;
		end else if (machine_tick && wd_run) begin
			pre_r <= (pre_r == pre_last) ? '0 : pre_r + 8'h01;
		end
	end

	// [R1] Counter behind the prescaler chain
	always_ff @(posedge i_clk) begin
		if (!i_rstn || int_rst) begin
			// [R9] Cleared on reset
			cnt_r <= '0;
		end else if (wdc_r[WDC_CLEAR] && machine_tick) begin
			// [R4] Counter cleared with prescaler
			cnt_r <= '0;
		end else if (pre_tick) begin
			cnt_r <= cnt_r + 14'h0001;
		end
	end

	// [R1] Timeout forces system reset when enabled; [R5] software must clear
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			wd_reset_r <= 1'b0;
		end else begin
			wd_reset_r <= timeout;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power mode

	// [R11] Idle exits on interrupt; [R12] power-down only by reset
	always_ff @(posedge i_clk) begin
		if (!i_rstn || int_rst) begin
			pmode_r <= PM_RUN;
		end else begin
			case (pmode_r)
				PM_RUN: begin
					if (wr_hit && aw_addr_r == ADDR_POWER_MODE_CONTROL && w_data_r[PMC_PDOWN]) begin
						pmode_r <= PM_PDOWN;
					end else if (wr_hit && aw_addr_r == ADDR_POWER_MODE_CONTROL &&
						w_data_r[PMC_IDLE]) begin
						pmode_r <= PM_IDLE;
					end
				end
				PM_IDLE: begin
					if (i_wake_irq) begin
						pmode_r <= PM_RUN;
					end
				end
				PM_PDOWN: pmode_r <= PM_PDOWN;
				default:  pmode_r <= PM_RUN;
			endcase
		end
	end

	// [R11] Processor clock gate; [R12] oscillator gate
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_cpu_clk_en <= 1'b1;
			o_osc_en     <= 1'b1;
		end else begin
			o_cpu_clk_en <= (pmode_r == PM_RUN) || int_rst;
			o_osc_en     <= (pmode_r != PM_PDOWN) || int_rst;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	assign wr_go  = aw_full_r && w_full_r && !o_bvalid;
	assign wr_hit = wr_go && w_lane0_r;

	// Watchdog control register
	always_ff @(posedge i_clk) begin
		if (!i_rstn || int_rst) begin
			// [R2] [R15] Disabled and cleared on reset
			wdc_r <= WDC_RESET;
		end else if (wr_hit && aw_addr_r == ADDR_WATCHDOG_CONTROL) begin
			wdc_r <= w_data_r[7:0];
		end else if (machine_tick && wdc_r[WDC_CLEAR]) begin
			// [R4] Clear bit self-clears
			wdc_r[WDC_CLEAR] <= 1'b0;
		end
	end

	// Power mode control register, mode bits mirror the state
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			pmc_r <= PMC_RESET[4:0];
		end else if (int_rst) begin
			// [R15] Cleared except power flag; [R16] set on power-on
			pmc_r <= {pmc_r[PMC_POWER_OFF] | i_power_on, 4'h0};
		end else begin
			// [R17] User flags, [R16] software clears flag
			if (wr_hit && aw_addr_r == ADDR_POWER_MODE_CONTROL) begin
				pmc_r[PMC_POWER_OFF:PMC_USER_ZERO] <= w_data_r[PMC_POWER_OFF:PMC_USER_ZERO];
			end
			pmc_r[PMC_PDOWN] <= (pmode_r == PM_PDOWN);
			pmc_r[PMC_IDLE]  <= (pmode_r == PM_IDLE);
		end
	end

	// Interrupt status, set wins over write-one-to-clear
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			irq_stat_r <= IRQ_RESET;
		end else begin
			irq_stat_r[IRQ_TIMEOUT] <= timeout | (irq_stat_r[IRQ_TIMEOUT] &
				~(wr_hit && aw_addr_r == ADDR_IRQ_STATUS && w_data_r[IRQ_TIMEOUT]));
			irq_stat_r[IRQ_WAKE] <= (pmode_r == PM_IDLE && i_wake_irq) | (irq_stat_r[IRQ_WAKE] &
				~(wr_hit && aw_addr_r == ADDR_IRQ_STATUS && w_data_r[IRQ_WAKE]));
		end
	end

	// Interrupt mask and output
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			irq_mask_r <= IRQ_RESET;
			o_irq      <= 1'b0;
		end else begin
			if (wr_hit && aw_addr_r == ADDR_IRQ_MASK) begin
				irq_mask_r <= w_data_r[1:0];
			end
			o_irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path, address and data taken in either order

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			aw_addr_r <= 12'h000;
			w_data_r  <= 32'h0000_0000;
			w_lane0_r <= 1'b0;
			o_awready <= 1'b0;
			o_wready  <= 1'b0;
			o_bvalid  <= 1'b0;
			o_bresp   <= RESP_OKAY;
		end else begin
			// Held low until the pending response is accepted
			o_awready <= !aw_full_r && !(i_awvalid && o_awready) && !(o_bvalid && !i_bready);
			o_wready  <= !w_full_r && !(i_wvalid && o_wready);
			if (i_awvalid && o_awready) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= {i_awaddr[11:2], 2'h0};
			end
			if (i_wvalid && o_wready) begin
				w_full_r  <= 1'b1;
				w_data_r  <= i_wdata;
				w_lane0_r <= i_wstrb[0];
			end
			if (wr_go) begin
				aw_full_r <= 1'b0;
				w_full_r  <= 1'b0;
				o_bvalid  <= 1'b1;
				o_bresp   <= (aw_addr_r == ADDR_POWER_MODE_CONTROL ||
					aw_addr_r == ADDR_WATCHDOG_CONTROL || aw_addr_r == ADDR_IRQ_STATUS ||
					aw_addr_r == ADDR_IRQ_MASK || aw_addr_r == ADDR_WDT_COUNT) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path

	// Read decode
	always_comb begin
		rd_beat.resp = RESP_OKAY;
		if ({i_araddr[11:2], 2'h0} == ADDR_POWER_MODE_CONTROL) begin
			rd_beat.data = {27'h0, pmc_r};
		end else if ({i_araddr[11:2], 2'h0} == ADDR_WATCHDOG_CONTROL) begin
			rd_beat.data = {24'h0, wdc_r};
		end else if ({i_araddr[11:2], 2'h0} == ADDR_IRQ_STATUS) begin
			rd_beat.data = {30'h0, irq_stat_r};
		end else if ({i_araddr[11:2], 2'h0} == ADDR_IRQ_MASK) begin
			rd_beat.data = {30'h0, irq_mask_r};
		end else if ({i_araddr[11:2], 2'h0} == ADDR_WDT_COUNT) begin
			rd_beat.data = {18'h0, cnt_r};
		end else begin
			rd_beat.data = 32'h0000_0000;
			rd_beat.resp = RESP_SLVERR;
		end
	end

	// Single outstanding read
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0000_0000;
			o_rresp   <= RESP_OKAY;
		end else begin
			o_arready <= !o_rvalid && !(i_arvalid && o_arready);
			if (i_arvalid && o_arready) begin
				o_rvalid <= 1'b1;
				o_rdata  <= rd_beat.data;
				o_rresp  <= rd_beat.resp;
			end else if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

endmodule

// file: wdt_check_properties.sv
// Port-level timing checks of the watchdog block
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module wdt_check
	import wdt_pkg::*;
(
	// Clock and resets
	input logic        i_clk,
	input logic        i_rstn,
	input logic        i_ext_reset,
	// Register bus
	input logic [11:0] i_araddr,
	input logic        i_arvalid,
	input logic        o_arready,
	input logic [31:0] o_rdata,
	input logic [1:0]  o_rresp,
	input logic        o_rvalid,
	input logic        i_rready,
	input logic        i_awvalid,
	input logic        o_awready,
	input logic        i_wvalid,
	input logic        o_wready,
	input logic [1:0]  o_bresp,
	input logic        o_bvalid,
	input logic        i_bready,
	// System outputs
	input logic        o_half_clk,
	input logic        o_cpu_clk_en,
	input logic        o_osc_en,
	input logic        o_sys_reset
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	logic [5:0] pin_cnt_r;
	logic       unmapped;
	// Run length of the reset pin; saturates so a long hold stays high
	always_ff @(posedge i_clk) begin
		if (!i_ext_reset) pin_cnt_r <= 6'h00;
		else if (pin_cnt_r != 6'h3F) pin_cnt_r <= pin_cnt_r + 6'h01;
	end
	// Read address outside the map
	assign unmapped = (i_araddr[11:10] != 2'h0) || !(i_araddr[9:2] inside {IDX_POWER_MODE_CONTROL,
		IDX_WATCHDOG_CONTROL, IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_WDT_COUNT});
	sequence wr_taken;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence
	sequence rd_taken;
		i_arvalid && o_arready;
	endsequence
	chk_wr_answer: assert property (wr_taken |-> ##2 o_bvalid)
		else $error("write response not in time");
	chk_rd_answer: assert property (rd_taken |=> o_rvalid)
		else $error("read data not in time");
	chk_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped");
	chk_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped");
	chk_aw_blocked: assert property (o_bvalid |-> !o_awready)
		else $error("write address taken while answering");
	chk_unmapped_err: assert property (rd_taken ##0 unmapped |=> o_rresp == RESP_SLVERR && o_rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_half_toggle: assert property (
		o_osc_en && $past(o_osc_en) && $past(i_rstn) && !o_sys_reset && !$past(o_sys_reset)
		|-> o_half_clk != $past(o_half_clk)) else $error("half clock stuck");
	chk_pdown_exit: assert property (!o_osc_en && !o_sys_reset |=> !o_osc_en || o_sys_reset)
		else $error("power-down left without reset");
	chk_pdown_cpu: assert property (!o_osc_en |-> !o_cpu_clk_en)
		else $error("cpu clock on in power-down");
	chk_pin_reset: assert property (pin_cnt_r >= 6'h28 |-> o_sys_reset)
		else $error("held reset pin ignored");
endmodule
bind wdt_top wdt_check u_wdt_check (.i_clk, .i_rstn, .i_ext_reset, .i_araddr, .i_arvalid,
	.o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_awvalid, .o_awready, .i_wvalid,
	.o_wready, .o_bresp, .o_bvalid, .i_bready, .o_half_clk, .o_cpu_clk_en, .o_osc_en, .o_sys_reset);

// file: tb.sv
// Self-checking bench of the watchdog and power control block
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module tb;
	import wdt_pkg::*;
	logic        i_clk = 1'b0, i_rstn = 1'b0, i_ext_reset = 1'b0;
	logic        i_power_on = 1'b1, i_wake_irq = 1'b0;
	logic [11:0] i_awaddr = 12'h000, i_araddr = 12'h000;
	logic [31:0] i_wdata = 32'h0, o_rdata, d;
	logic [3:0]  i_wstrb = 4'hF;
	logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
	logic        i_arvalid = 1'b0, i_rready = 1'b0;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0]  o_bresp, o_rresp, r;
	logic        o_half_clk, o_cpu_clk_en, o_osc_en, o_sys_reset, o_irq;
	logic        lazy = 1'b0;
	int          err_count = 0, cmp_count = 0, cyc = 0;
	wdt_top u_wdt_top (.i_clk, .i_rstn, .i_ext_reset, .i_power_on, .i_wake_irq, .i_awaddr,
		.i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
		.i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
		.o_half_clk, .o_cpu_clk_en, .o_osc_en, .o_sys_reset, .o_irq);
	////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial forever #5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			conclude();
		end
	end
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// Bus write; lazy holds bready back to stall the answer
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge i_clk);
		i_awaddr <= a;
		i_wdata <= {24'h0, v};
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= !lazy;
		forever begin
			@(posedge i_clk);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
			if (o_bvalid && i_bready) break;
			if (o_bvalid) i_bready <= 1'b1;
		end
		r = o_bresp;
		i_bready <= 1'b0;
	endtask
	// Bus read, same stall option
	task automatic rd(input logic [11:0] a);
		@(posedge i_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= !lazy;
		forever begin
			@(posedge i_clk);
			if (o_arready) i_arvalid <= 1'b0;
			if (o_rvalid && i_rready) break;
			if (o_rvalid) i_rready <= 1'b1;
		end
		d = o_rdata;
		r = o_rresp;
		i_rready <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////
	// Reset values, user flags, refused addresses
	task automatic t_regs();
		rd(ADDR_POWER_MODE_CONTROL);
		chk("pmc_por", d, 32'h10);
		rd(ADDR_WATCHDOG_CONTROL);
		chk("wdc_rst", d, 32'h0);
		wr(ADDR_POWER_MODE_CONTROL, 8'h0C);
		rd(ADDR_POWER_MODE_CONTROL);
		chk("pmc_flags", d, 32'h0C);
		tick(100);
		rd(ADDR_WDT_COUNT);
		chk("cnt_off", d, 32'h0);
		lazy = 1'b1;
		rd(12'h300);
		chk("rd_err", {30'h0, r}, {30'h0, RESP_SLVERR});
		wr(12'h300, 8'h00);
		chk("wr_err", {30'h0, r}, {30'h0, RESP_SLVERR});
		lazy = 1'b0;
	endtask
	// Every prescaler code, clear bit self-clearing
	task automatic t_prescale();
		int div [8] = '{2, 8, 4, 16, 32, 64, 128, 256};
		for (int ps = 0; ps < 8; ps++) begin
			// Software clears long before the interval runs out
			wr(ADDR_WATCHDOG_CONTROL, 8'hC0 | 8'(ps));
			tick(48 * div[ps]);
			rd(ADDR_WDT_COUNT);
			chk("cnt_rate", 32'(d == 32'h3 || d == 32'h4), 32'h1);
			rd(ADDR_WATCHDOG_CONTROL);
			chk("clr_self", d, 32'h80 | 32'(ps));
		end
	endtask
	// Idle halt and wake, interrupt mask and clear, idle-run
	task automatic t_idle();
		logic [31:0] c0;
		wr(ADDR_IRQ_MASK, 8'h00);
		wr(ADDR_WATCHDOG_CONTROL, 8'hC0);
		wr(ADDR_POWER_MODE_CONTROL, 8'h01);
		tick(2);
		chk("cpu_idle", o_cpu_clk_en, 1'b0);
		// Let the pending clear land before taking the reference count
		tick(12);
		rd(ADDR_WDT_COUNT);
		c0 = d;
		tick(200);
		rd(ADDR_WDT_COUNT);
		chk("cnt_hold", d, c0);
		i_wake_irq <= 1'b1;
		tick(3);
		chk("cpu_wake", o_cpu_clk_en, 1'b1);
		i_wake_irq <= 1'b0;
		chk("irq_masked", o_irq, 1'b0);
		wr(ADDR_IRQ_MASK, 8'h02);
		tick(2);
		chk("irq_on", o_irq, 1'b1);
		wr(ADDR_IRQ_STATUS, 8'h02);
		tick(2);
		chk("irq_clr", o_irq, 1'b0);
		wr(ADDR_WATCHDOG_CONTROL, 8'hC8);
		wr(ADDR_POWER_MODE_CONTROL, 8'h01);
		tick(12);
		rd(ADDR_WDT_COUNT);
		c0 = d;
		tick(200);
		rd(ADDR_WDT_COUNT);
		chk("cnt_idle_run", 32'(d == c0), 32'h0);
		i_wake_irq <= 1'b1;
		tick(3);
		i_wake_irq <= 1'b0;
	endtask
	// Power-down, reset glitch, real pin reset
	task automatic t_pdown();
		wr(ADDR_POWER_MODE_CONTROL, 8'h0E);
		i_wake_irq <= 1'b1;
		tick(20);
		chk("osc_off", {o_osc_en, o_cpu_clk_en}, 2'b00);
		i_wake_irq <= 1'b0;
		i_ext_reset <= 1'b1;
		tick(10);
		i_ext_reset <= 1'b0;
		tick(20);
		chk("glitch", {o_sys_reset, o_osc_en}, 2'b00);
		i_ext_reset <= 1'b1;
		tick(40);
		chk("pin_rst", o_sys_reset, 1'b1);
		i_ext_reset <= 1'b0;
		tick(40);
		chk("osc_back", {o_sys_reset, o_osc_en}, 2'b01);
		rd(ADDR_WATCHDOG_CONTROL);
		chk("wdc_clr", d, 32'h0);
		rd(ADDR_POWER_MODE_CONTROL);
		chk("pmc_clr", d, 32'h0);
		rd(ADDR_WDT_COUNT);
		chk("cnt_clr", d, 32'h0);
	endtask
	////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (4) @(posedge i_clk);
		i_rstn <= 1'b1;
		tick(3);
		i_power_on <= 1'b0;
		tick(30);
		t_regs();
		t_prescale();
		t_idle();
		t_pdown();
		conclude();
	end
endmodule
